// [rtl/svr_pkg.sv]
// Shared constants and types for the serial regulator register bank
package svr_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CAPABILITY = 8'h06;
    localparam logic [7:0] ADDR_PRIM_STATUS = 8'h10;
    localparam logic [7:0] ADDR_SEC_STATUS = 8'h11;
    localparam logic [7:0] ADDR_THERMAL_ZONE = 8'h12;
    localparam logic [7:0] ADDR_SNAPSHOT = 8'h1c;
    localparam logic [7:0] ADDR_CURRENT_LIMIT = 8'h21;
    localparam logic [7:0] ADDR_TEMP_LIMIT = 8'h22;
    localparam logic [7:0] ADDR_FAST_SLEW = 8'h24;
    localparam logic [7:0] ADDR_SLOW_SLEW = 8'h25;
    localparam logic [7:0] ADDR_BOOT_VOLTAGE = 8'h26;
    localparam logic [7:0] ADDR_CEILING = 8'h30;
    localparam logic [7:0] ADDR_SETTING = 8'h31;
    localparam logic [7:0] ADDR_POWER_STATE = 8'h32;
    localparam logic [7:0] ADDR_OFFSET = 8'h33;
    localparam logic [7:0] ADDR_MULTI_CFG = 8'h34;
    // Reset and fixed values
    localparam logic [7:0] CAPABILITY_VALUE = 8'h81;
    localparam logic [7:0] FAST_SLEW_VALUE = 8'h0a;
    localparam logic [7:0] SLOW_SLEW_VALUE = 8'h02;
    localparam logic [7:0] CEILING_RESET = 8'hfb;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    localparam logic [7:0] MULTI_CFG_FIRST = 8'h00;
    localparam logic [7:0] MULTI_CFG_SECOND = 8'h01;
    // Field positions
    localparam int PRIM_SETTLED_BIT = 0;
    localparam int PRIM_OVERTEMP_BIT = 1;
    localparam int PRIM_CURLIM_BIT = 2;
    localparam int SEC_CODE_REJECT_BIT = 0;
    localparam int SEC_RO_WRITE_BIT = 1;
    localparam int OFFSET_SIGN_BIT = 7;
    // Ramp timing: one code step per interval
    localparam int CLK_MHZ = 50;
    localparam int STEP_TIME_NS = 500;
    localparam int STEP_CYCLES = (STEP_TIME_NS * CLK_MHZ) / 1000;
    // Command kinds and answers
    typedef enum logic [1:0] {
        KIND_READ = 2'h0, KIND_WRITE = 2'h1, KIND_SET_VOLTAGE = 2'h2, KIND_NONE = 2'h3
    } svr_kind_t;
    typedef enum logic [1:0] {
        ACK_OK = 2'h0, ACK_NOT_SUPPORTED = 2'h1, ACK_REJECT = 2'h2
    } svr_ack_t;
    typedef struct packed {
        svr_kind_t kind;
        logic [7:0] addr;
        logic [7:0] data;
    } svr_req_t;
    typedef struct packed {
        svr_ack_t ack;
        logic [7:0] data;
    } svr_resp_t;
endpackage : svr_pkg

// [rtl/svr_register_bank.sv]
// Register bank for one regulator output, reached over the serial command link
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Primary status shows settled, overtemperature and current-limit; resets to zero.
// - Snapshot holds secondary status as returned by its last read command.
// - Thermal zone register shows entered zones; resets to zero.
// - Current limit loaded from strap at start-up, binary amperes.
// - Temperature limit loaded from strap at start-up, binary degrees Celsius.
// - Fast slew rate reads 0Ah, binary millivolts per microsecond.
// - Slow slew rate reads 02h, five times slower than fast.
// - Boot code targeted at start-up and held until a set command or setting write is accepted.
// - Ceiling register defaults FBh; higher requested codes get not-supported.
// - Voltage setting holds programmed code; resets to zero.
// - Power state register holds programmed power state; resets to zero.
// - Shared-bus config resets 00h on first output, 01h on second.
// - Capability register reads 81h.
// - Any primary status change raises the attention line.
// - Reading primary status releases the attention line unless the status changes in the same cycle.
module svr_register_bank import svr_pkg::*; #(
    parameter int OUTPUT_INDEX = 0,
    parameter int STEP_INTERVAL = STEP_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic linkClk,
    input wire logic linkReset,
    input wire logic cmdValid,
    input wire svr_req_t cmdReq,
    output logic cmdReady,
    output logic respValid,
    output svr_resp_t resp,
    input wire logic overtempPin,
    input wire logic currentLimitPin,
    input wire logic [7:0] thermalZonePin,
    input wire logic [7:0] currentStrap,
    input wire logic [7:0] tempStrap,
    input wire logic [7:0] bootStrap,
    output logic alertN,
    output logic [7:0] voltageCode,
    output logic [7:0] powerState
);
    localparam logic [7:0] MULTI_CFG_RESET = (OUTPUT_INDEX == 0) ? MULTI_CFG_FIRST : MULTI_CFG_SECOND;
    localparam logic [15:0] STEP_MAX = 16'(STEP_INTERVAL - 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } svr_state_t;

    // Signed margin applied to a base code, saturated to 0..255
    function automatic logic [7:0] applyMargin(input logic [7:0] base, input logic [7:0] off);
        logic [8:0] sum;
        sum = 9'h000;
        if (off[OFFSET_SIGN_BIT]) begin
            sum = {1'b0, base} - {2'b00, off[6:0]};
            applyMargin = sum[8] ? 8'h00 : sum[7:0];
        end else begin
            sum = {1'b0, base} + {2'b00, off[6:0]};
            applyMargin = sum[8] ? 8'hff : sum[7:0];
        end
    endfunction : applyMargin
    // Link domain: command capture and answer strobe
    logic ready_q;
    logic reqTgl_q;
    svr_req_t reqHold_q;
    logic ackSync1_q, ackSync2_q, ackSeen_q;
    logic respValid_q;
    svr_resp_t respOut_q;
    logic ackTgl_q;
    svr_resp_t coreResp_q;

    // Capture a command and flag it to the core with a toggle
    always_ff @(posedge linkClk) begin
        if (linkReset) begin
            ready_q <= 1'b1;
            reqTgl_q <= 1'b0;
            reqHold_q <= '{kind: KIND_NONE, addr: 8'h00, data: 8'h00};
        end else if (cmdValid && ready_q) begin
            ready_q <= 1'b0;
            reqTgl_q <= ~reqTgl_q;
            reqHold_q <= cmdReq;
        end else if (ackSync2_q != ackSeen_q) begin
            ready_q <= 1'b1;
        end
    end

    // Answer toggle from the core, two-stage synchroniser
    always_ff @(posedge linkClk) begin
        if (linkReset) begin
            {ackSync1_q, ackSync2_q, ackSeen_q} <= 3'b000;
        end else begin
            {ackSync1_q, ackSync2_q, ackSeen_q} <= {ackTgl_q, ackSync1_q, ackSync2_q};
        end
    end

    // One-cycle answer strobe; core answer is stable by now
    always_ff @(posedge linkClk) begin
        if (linkReset) begin
            respValid_q <= 1'b0;
            respOut_q <= '{ack: ACK_OK, data: 8'h00};
        end else begin
            respValid_q <= (ackSync2_q != ackSeen_q);
            if (ackSync2_q != ackSeen_q) begin
                respOut_q <= coreResp_q;
            end
        end
    end

    assign cmdReady = ready_q;
    assign respValid = respValid_q;
    assign resp = respOut_q;
    // Core domain: registers, status and output ramp
    logic reqSync1_q, reqSync2_q, reqSeen_q;
    logic otSync1_q, otSync2_q, clSync1_q, clSync2_q;
    logic [7:0] tzSync1_q, tzSync2_q;
    logic [7:0] curSync1_q, curSync2_q, tmpSync1_q, tmpSync2_q, bootSync1_q, bootSync2_q;
    svr_state_t state_q;
    svr_req_t req;
    logic [7:0] currentLimit_q, tempLimit_q, bootCode_q;
    logic [7:0] ceiling_q, setting_q, powerState_q, offset_q, multiCfg_q;
    logic [7:0] primStatus_q, secStatus_q, snapshot_q, thermalZone_q;
    logic settingLoaded_q, strapTaken_q;
    logic alertN_q;
    logic [7:0] outCode_q;
    logic [15:0] stepCnt_q;
    logic [7:0] primNew, readData, targetCode;
    logic execRead, execWrite, execSet, codeTooHigh, roWrite, mapped;

    // Pin and link synchronisers, two flops each
    always_ff @(posedge clk) begin
        if (reset) begin
            {reqSync1_q, reqSync2_q, otSync1_q, otSync2_q, clSync1_q, clSync2_q} <= 6'b000000;
            {tzSync1_q, tzSync2_q} <= 16'h0000;
        end else if (ce) begin
            reqSync1_q <= reqTgl_q;
            reqSync2_q <= reqSync1_q;
            {otSync1_q, clSync1_q, tzSync1_q} <= {overtempPin, currentLimitPin, thermalZonePin};
            {otSync2_q, clSync2_q, tzSync2_q} <= {otSync1_q, clSync1_q, tzSync1_q};
        end
    end

    // Strap synchronisers run through reset so the value is ready at release
    always_ff @(posedge clk) begin
        {curSync1_q, tmpSync1_q, bootSync1_q} <= {currentStrap, tempStrap, bootStrap};
        {curSync2_q, tmpSync2_q, bootSync2_q} <= {curSync1_q, tmpSync1_q, bootSync1_q};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            strapTaken_q <= 1'b0;
            {currentLimit_q, tempLimit_q, bootCode_q} <= {ZERO_RESET, ZERO_RESET, ZERO_RESET};
        end else if (ce && !strapTaken_q) begin // Synchronisers hold the straps by now
            strapTaken_q <= 1'b1;
            {currentLimit_q, tempLimit_q, bootCode_q} <= {curSync2_q, tmpSync2_q, bootSync2_q};
        end
    end

    assign req = reqHold_q;
    assign execRead = (state_q == ST_EXEC) && (req.kind == KIND_READ);
    assign execWrite = (state_q == ST_EXEC) && (req.kind == KIND_WRITE);
    assign execSet = (state_q == ST_EXEC) && (req.kind == KIND_SET_VOLTAGE);
    assign codeTooHigh = req.data > ceiling_q;
    assign roWrite = execWrite && !(req.addr >= ADDR_CEILING && req.addr <= ADDR_MULTI_CFG);

    // Read mux over the whole map
    always_comb begin
        mapped = 1'b1;
        readData = 8'h00;
        unique case (req.addr)
            ADDR_CAPABILITY: readData = CAPABILITY_VALUE;
            ADDR_PRIM_STATUS: readData = primStatus_q;
            ADDR_SEC_STATUS: readData = secStatus_q;
            ADDR_THERMAL_ZONE: readData = thermalZone_q;
            ADDR_SNAPSHOT: readData = snapshot_q;
            ADDR_CURRENT_LIMIT: readData = currentLimit_q;
            ADDR_TEMP_LIMIT: readData = tempLimit_q;
            ADDR_FAST_SLEW: readData = FAST_SLEW_VALUE;
            ADDR_SLOW_SLEW: readData = SLOW_SLEW_VALUE;
            ADDR_BOOT_VOLTAGE: readData = bootCode_q;
            ADDR_CEILING: readData = ceiling_q;
            ADDR_SETTING: readData = setting_q;
            ADDR_POWER_STATE: readData = powerState_q;
            ADDR_OFFSET: readData = offset_q;
            ADDR_MULTI_CFG: readData = multiCfg_q;
            default: mapped = 1'b0;
        endcase
    end

    // Command sequencer and answer toggle
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            reqSeen_q <= 1'b0;
            ackTgl_q <= 1'b0;
            coreResp_q <= '{ack: ACK_OK, data: 8'h00};
        end else if (ce) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (reqSync2_q != reqSeen_q) begin
                        reqSeen_q <= reqSync2_q;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_q <= ST_IDLE;
                    ackTgl_q <= ~ackTgl_q;
                    coreResp_q.data <= execRead ? readData : 8'h00;
                    if (execRead) begin
                        coreResp_q.ack <= mapped ? ACK_OK : ACK_REJECT;
                    end else if (execSet || (execWrite && req.addr == ADDR_SETTING)) begin
                        coreResp_q.ack <= codeTooHigh ? ACK_NOT_SUPPORTED : ACK_OK;
                    end else if (execWrite) begin
                        coreResp_q.ack <= roWrite ? ACK_REJECT : ACK_OK;
                    end else begin
                        coreResp_q.ack <= ACK_REJECT;
                    end
                end
            endcase
        end
    end

    // Writable registers; read-only ones are absent here
    // writes outside the writable range only set the read-only-write bit of the secondary status
    always_ff @(posedge clk) begin
        if (reset) begin
            ceiling_q <= CEILING_RESET;
            powerState_q <= ZERO_RESET;
            offset_q <= ZERO_RESET;
            multiCfg_q <= MULTI_CFG_RESET;
        end else if (ce && execWrite) begin
            unique case (req.addr)
                ADDR_CEILING: ceiling_q <= req.data;
                ADDR_POWER_STATE: powerState_q <= req.data;
                ADDR_OFFSET: offset_q <= req.data;
                ADDR_MULTI_CFG: multiCfg_q <= req.data;
                default: ;
            endcase
        end
    end

    // programmed code, loaded only when within the ceiling
    // boot code stands until the first accepted setting
    always_ff @(posedge clk) begin
        if (reset) begin
            setting_q <= ZERO_RESET;
            settingLoaded_q <= 1'b0;
        end else if (ce && (execSet || (execWrite && req.addr == ADDR_SETTING)) && !codeTooHigh) begin
            setting_q <= req.data;
            settingLoaded_q <= 1'b1;
        end
    end

    // signed margin on the active code
    assign targetCode = applyMargin(settingLoaded_q ? setting_q : bootCode_q, offset_q);
    // Output code ramps one step per interval toward the target
    always_ff @(posedge clk) begin
        if (reset) begin
            outCode_q <= 8'h00;
            stepCnt_q <= 16'h0000;
        end else if (ce) begin
            if (outCode_q == targetCode) begin
                stepCnt_q <= 16'h0000;
            end else if (stepCnt_q == STEP_MAX) begin
                stepCnt_q <= 16'h0000;
                outCode_q <= (outCode_q < targetCode) ? outCode_q + 8'h01 : outCode_q - 8'h01;
            end else begin
                stepCnt_q <= stepCnt_q + 16'h0001;
            end
        end
    end

    always_comb begin
        primNew = 8'h00;
        primNew[PRIM_SETTLED_BIT] = strapTaken_q && (outCode_q == targetCode); // No false settle before straps
        primNew[PRIM_OVERTEMP_BIT] = otSync2_q;
        primNew[PRIM_CURLIM_BIT] = clSync2_q;
    end

    // Status registers, snapshot and attention line
    always_ff @(posedge clk) begin
        if (reset) begin
            primStatus_q <= ZERO_RESET;
            secStatus_q <= ZERO_RESET;
            snapshot_q <= ZERO_RESET;
            thermalZone_q <= ZERO_RESET;
            alertN_q <= 1'b1;
        end else if (ce) begin
            primStatus_q <= primNew;
            thermalZone_q <= tzSync2_q;
            // change raises the line; set wins over release
            // read of primary status releases it
            if (primNew != primStatus_q) begin
                alertN_q <= 1'b0;
            end else if (execRead && req.addr == ADDR_PRIM_STATUS) begin
                alertN_q <= 1'b1;
            end
            // copy of the value returned to the master
            if (execRead && req.addr == ADDR_SEC_STATUS) begin
                snapshot_q <= secStatus_q;
            end
            // Sticky error bits, cleared on read, new events win
            secStatus_q <= ((execRead && req.addr == ADDR_SEC_STATUS) ? 8'h00 : secStatus_q)
                | (8'((execSet && codeTooHigh) ? 1 : 0) << SEC_CODE_REJECT_BIT)
                | (8'(roWrite ? 1 : 0) << SEC_RO_WRITE_BIT);
        end
    end

    assign alertN = alertN_q;
    assign voltageCode = outCode_q;
    assign powerState = powerState_q;
    // Checks on the core clock unless a clock is named
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_alert_on_change: assert property (ce && $changed(primStatus_q) |-> !alertN_q)
        else $error("status change without attention");
    a_alert_release: assert property (ce && execRead && req.addr == ADDR_PRIM_STATUS
        && primNew == primStatus_q |=> alertN_q)
        else $error("attention not released after read");
    a_snapshot_copy: assert property (ce && execRead && req.addr == ADDR_SEC_STATUS
        |=> snapshot_q == coreResp_q.data && coreResp_q.data == $past(secStatus_q))
        else $error("snapshot differs from returned value");
    a_ceiling_reject: assert property (ce && execSet && codeTooHigh
        |=> coreResp_q.ack == ACK_NOT_SUPPORTED && $stable(setting_q))
        else $error("over-ceiling code accepted");
    a_setting_load: assert property (ce && execSet && !codeTooHigh
        |=> setting_q == $past(req.data) && settingLoaded_q)
        else $error("setting not loaded");
    a_ro_untouched: assert property (ce && roWrite
        |=> coreResp_q.ack == ACK_REJECT && $stable(currentLimit_q) && $stable(ceiling_q))
        else $error("read-only write took effect");
    a_cap_value: assert property (ce && execRead && req.addr == ADDR_CAPABILITY
        |=> coreResp_q.data == CAPABILITY_VALUE)
        else $error("capability value wrong");
    a_ramp_step: assert property ($changed(outCode_q) |-> $past(stepCnt_q) == STEP_MAX && $past(ce))
        else $error("output code stepped early");
    a_margin_sign: assert property (settingLoaded_q && offset_q == 8'h83 && setting_q > 8'h02
        |-> targetCode == setting_q - 8'h03)
        else $error("negative margin wrong");
    a_resp_pulse: assert property (@(posedge linkClk) disable iff (linkReset)
        respValid_q |=> !respValid_q)
        else $error("answer strobe longer than one cycle");

    c_set_ok: cover property (ce && execSet && !codeTooHigh);
    c_set_refused: cover property (ce && execSet && codeTooHigh);
    c_alert_cycle: cover property (!alertN_q ##[1:200] alertN_q);
    c_snapshot_read: cover property (ce && execRead && req.addr == ADDR_SNAPSHOT);
endmodule : svr_register_bank

`default_nettype wire

// [verification/svr_link_master.sv]
// Link master model: offers one command at a time and collects its answer
`timescale 1ns/10ps
`default_nettype none
module svr_link_master import svr_pkg::*; (
    input wire logic linkClk,
    input wire logic cmdReady,
    input wire logic respValid,
    input wire svr_resp_t resp,
    output logic cmdValid,
    output svr_req_t cmdReq
);
    // Idle request lines at time zero
    initial begin
        cmdValid = 1'b0;
        cmdReq = '0;
    end
    // One transfer: hold until taken, then wait for the answer pulse
    task automatic xfer(input svr_req_t req, output svr_resp_t got);
        int n;
        n = 0;
        @(posedge linkClk);
        cmdValid <= 1'b1;
        cmdReq <= req;
        do @(posedge linkClk); while (cmdReady !== 1'b1);
        // Released lines show a changed pattern, not the old command
        cmdValid <= 1'b0;
        cmdReq <= ~req;
        while (respValid !== 1'b1 && n < 200) begin
            @(posedge linkClk);
            n++;
        end
        got = (n < 200) ? resp : '1; // No answer gives an invalid code
    endtask : xfer
endmodule : svr_link_master
`default_nettype wire

// [verification/svr_register_bank_bench.sv]
// Self-checking bench for the regulator register bank
`timescale 1ns/10ps
`default_nettype none
module svr_register_bank_bench import svr_pkg::*;;
    localparam int STEP = 2;
    logic clk;
    logic linkClk;
    logic reset = 1'b1;
    logic linkReset = 1'b1;
    logic ce = 1'b1;
    logic overtempPin = 1'b0;
    logic currentLimitPin = 1'b0;
    logic [7:0] thermalZonePin = 8'h00;
    logic [7:0] currentStrap = 8'h64;
    logic [7:0] tempStrap = 8'h55;
    logic [7:0] bootStrap = 8'h20;
    logic cmdValid, cmdReady, respValid, alertN;
    logic [7:0] voltageCode, powerState;
    svr_req_t cmdReq;
    svr_resp_t resp, got, resp2;
    int errorCnt = 0;
    int checks = 0;
    logic [7:0] regAddr [13] = '{8'h06, 8'h11, 8'h12, 8'h1c, 8'h21, 8'h22, 8'h24, 8'h25, 8'h30, 8'h31, 8'h32,
                                 8'h33, 8'h34};
    logic [7:0] regRst [13] = '{8'h81, 8'h00, 8'h00, 8'h00, 8'h64, 8'h55, 8'h0a, 8'h02, 8'hfb, 8'h00, 8'h00,
                                8'h00, 8'h00};

    svr_register_bank #(.OUTPUT_INDEX(0), .STEP_INTERVAL(STEP)) i_dut (
        .clk(clk), .reset(reset), .ce(ce), .linkClk(linkClk), .linkReset(linkReset),
        .cmdValid(cmdValid), .cmdReq(cmdReq), .cmdReady(cmdReady), .respValid(respValid), .resp(resp),
        .overtempPin(overtempPin), .currentLimitPin(currentLimitPin), .thermalZonePin(thermalZonePin),
        .currentStrap(currentStrap), .tempStrap(tempStrap), .bootStrap(bootStrap),
        .alertN(alertN), .voltageCode(voltageCode), .powerState(powerState)
    );
    // Second output's copy on the same commands, for its own reset value
    svr_register_bank #(.OUTPUT_INDEX(1), .STEP_INTERVAL(STEP)) i_dut2 (
        .clk(clk), .reset(reset), .ce(ce), .linkClk(linkClk), .linkReset(linkReset),
        .cmdValid(cmdValid), .cmdReq(cmdReq), .cmdReady(), .respValid(), .resp(resp2),
        .overtempPin(overtempPin), .currentLimitPin(currentLimitPin), .thermalZonePin(thermalZonePin),
        .currentStrap(currentStrap), .tempStrap(tempStrap), .bootStrap(bootStrap),
        .alertN(), .voltageCode(), .powerState()
    );
    svr_link_master i_master (
        .linkClk(linkClk), .cmdReady(cmdReady), .respValid(respValid), .resp(resp),
        .cmdValid(cmdValid), .cmdReq(cmdReq)
    );

    // Core clock, 20 ns
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Link clock, 6 ns, offset in phase
    initial begin
        linkClk = 1'b0;
        #1.7;
        forever #3 linkClk = ~linkClk;
    end

    // Compare and count
    task automatic chk(input logic [9:0] gotV, input logic [9:0] expV, input string what);
        checks++;
        if (gotV !== expV) begin
            errorCnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, gotV, expV);
        end
    endtask : chk
    // One command with its expected answer code and read data
    task automatic cmd(input svr_kind_t k, input logic [7:0] a, input logic [7:0] d, input svr_ack_t ack,
                       input logic [7:0] expD);
        i_master.xfer(svr_req_t'{k, a, d}, got);
        chk({8'h00, got.ack}, {8'h00, ack}, "answer code");
        if (k == KIND_READ && ack == ACK_OK)
            chk({2'b00, got.data}, {2'b00, expD}, "read data");
    endtask : cmd
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cmd(KIND_READ, a, 8'h00, ACK_OK, e);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input svr_ack_t ack);
        cmd(KIND_WRITE, a, d, ack, 8'h00);
    endtask : wr
    task automatic set_v(input logic [7:0] d, input svr_ack_t ack);
        cmd(KIND_SET_VOLTAGE, 8'h00, d, ack, 8'h00);
    endtask : set_v
    // Bounded wait for the applied code
    task automatic wait_code(input logic [7:0] e);
        for (int i = 0; i < 1000 && voltageCode !== e; i++) @(posedge clk);
        chk({2'b00, voltageCode}, {2'b00, e}, "applied code");
    endtask : wait_code
    // Bounded wait for the attention line
    task automatic wait_alert();
        for (int i = 0; i < 100 && alertN !== 1'b0; i++) @(posedge clk);
        chk({9'h000, alertN}, 10'h000, "attention raised");
    endtask : wait_alert

    // Verdict and end of run
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // Watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk);
        errorCnt++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge linkClk);
        linkReset <= 1'b0;
        // Start-up ramp to the strapped boot code
        wait_code(8'h20);
        wait_alert();
        rd(ADDR_PRIM_STATUS, 8'h01);
        chk({9'h000, alertN}, 10'h001, "attention released");
        // Values after reset
        foreach (regAddr[i]) rd(regAddr[i], regRst[i]);
        chk({2'b00, resp2.data}, {2'b00, MULTI_CFG_SECOND}, "second output config");
        cmd(KIND_READ, 8'h40, 8'h00, ACK_REJECT, 8'h00);
        chk({2'b00, voltageCode}, 10'h020, "boot code held");
        // Ceiling refusals and the snapshot of the secondary status
        set_v(8'hfc, ACK_NOT_SUPPORTED);
        rd(ADDR_SEC_STATUS, 8'h01);
        rd(ADDR_SNAPSHOT, 8'h01);
        rd(ADDR_SEC_STATUS, 8'h00);
        rd(ADDR_SNAPSHOT, 8'h00);
        set_v(8'hfb, ACK_OK);
        wr(ADDR_CEILING, 8'h40, ACK_OK);
        rd(ADDR_CEILING, 8'h40);
        set_v(8'h41, ACK_NOT_SUPPORTED);
        wr(ADDR_SETTING, 8'h41, ACK_NOT_SUPPORTED);
        set_v(8'h40, ACK_OK);
        rd(ADDR_SETTING, 8'h40);
        wait_code(8'h40);
        // Signed margin on top of the setting
        wr(ADDR_OFFSET, 8'h83, ACK_OK);
        wait_code(8'h3d);
        rd(ADDR_SETTING, 8'h40);
        wr(ADDR_OFFSET, 8'h02, ACK_OK);
        wait_code(8'h42);
        wr(ADDR_OFFSET, 8'h00, ACK_OK);
        wait_code(8'h40);
        // Power state
        wr(ADDR_POWER_STATE, 8'h03, ACK_OK);
        rd(ADDR_POWER_STATE, 8'h03);
        chk({2'b00, powerState}, 10'h003, "power state");
        // Write to a read-only place and an unknown kind
        wr(ADDR_CAPABILITY, 8'h00, ACK_REJECT);
        rd(ADDR_CAPABILITY, CAPABILITY_VALUE);
        rd(ADDR_SEC_STATUS, 8'h03);
        cmd(KIND_NONE, 8'h00, 8'h00, ACK_REJECT, 8'h00);
        // Status pins raise the attention line
        rd(ADDR_PRIM_STATUS, 8'h01);
        @(posedge clk);
        overtempPin <= 1'b1;
        wait_alert();
        rd(ADDR_PRIM_STATUS, 8'h03);
        chk({9'h000, alertN}, 10'h001, "attention released");
        @(posedge clk);
        currentLimitPin <= 1'b1;
        thermalZonePin <= 8'h20;
        wait_alert();
        rd(ADDR_PRIM_STATUS, 8'h07);
        rd(ADDR_THERMAL_ZONE, 8'h20);
        print_verdict();
    end
endmodule : svr_register_bank_bench
`default_nettype wire
